/* rtl/rfc_flow_ctl.sv */
// Serial port with RTS/CTS flow control in six modes
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps

module rfc_flow_ctl
   import rfc_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [RFC_DW-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [RFC_DW-1:0] reg_rdata,
   input  wire logic              cts_n_pin,
   input  wire logic              rxd_pin,
   output logic                   txd_pin,
   output logic                   rts_n_pin
);

   typedef enum logic [1:0] {RFC_TX_IDLE, RFC_TX_LOAD, RFC_TX_SHIFT, RFC_TX_EXT} rfc_tx_e;

   // Pin synchronisers
   logic        cts_meta_reg;
   logic        cts_sync_reg;
   logic        rxd_meta_reg;
   logic        rxd_sync_reg;

   // Software-visible configuration
   logic [2:0]  flow_control_mode_number_reg;
   logic [2:0]  flow_control_mode_number_next;
   logic        sw_rts_reg;
   logic        sw_rts_next;
   logic [7:0]  ext_bits_reg;
   logic [7:0]  ext_bits_next;
   logic [15:0] baud_div_reg;
   logic [15:0] baud_div_next;
   logic [4:0]  rx_full_lvl_reg;
   logic [4:0]  rx_full_lvl_next;
   logic [4:0]  rx_res_lvl_reg;
   logic [4:0]  rx_res_lvl_next;
   logic [RFC_DW-1:0] rdata_reg;
   logic [RFC_DW-1:0] rdata_next;
   logic        rd_rx_reg;

   // Transmitter
   rfc_tx_e     tx_st_reg;
   rfc_tx_e     tx_st_next;
   logic [15:0] baud_cnt_reg;
   logic [15:0] baud_cnt_next;
   logic [3:0]  bit_cnt_reg;
   logic [3:0]  bit_cnt_next;
   logic [9:0]  tx_sh_reg;
   logic [9:0]  tx_sh_next;
   logic [7:0]  ext_cnt_reg;
   logic [7:0]  ext_cnt_next;
   logic        auto_rts_reg;
   logic        auto_rts_next;
   logic        dyn_rts_reg;
   logic        dyn_rts_next;
   logic        rts_reg;
   logic        rts_next;
   logic        txd_reg;
   logic        txd_next;

   logic        baud_tick;
   logic        cts_ok;
   logic        send_ok;
   logic        tx_pop;
   logic        wr_hit;
   logic        tx_wr;
   logic        rts_wr;
   logic        auto_mode;
   logic        hold_mode;

   logic [7:0]       txf_data;
   logic [RFC_TXAW:0] txf_level;
   logic             txf_empty;
   logic             txf_full;
   logic [7:0]       rxf_data;
   logic [RFC_RXAW:0] rxf_level;
   logic             rxf_empty;
   logic             rxf_full;
   logic             rx_valid;
   logic [7:0]       rx_byte;
   logic             rx_pop;

   // Two flip-flops on every pin input before any logic reads it
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         cts_meta_reg <= 1'b0;
         cts_sync_reg <= 1'b0;
         rxd_meta_reg <= 1'b1;
         rxd_sync_reg <= 1'b1;
      end
      else
      begin
         cts_meta_reg <= ~cts_n_pin;
         cts_sync_reg <= cts_meta_reg;
         rxd_meta_reg <= rxd_pin;
         rxd_sync_reg <= rxd_meta_reg;
      end
   end

   assign cts_ok = cts_sync_reg;

   // Register writes and reads
   always_comb
   begin
      wr_hit                        = reg_wr;
      tx_wr                         = wr_hit && (reg_addr == RFC_ADDR_TXDATA) && !txf_full;
      rts_wr                        = wr_hit && (reg_addr == RFC_ADDR_RTS);
      flow_control_mode_number_next = flow_control_mode_number_reg;
      sw_rts_next                   = sw_rts_reg;
      ext_bits_next                 = ext_bits_reg;
      baud_div_next                 = baud_div_reg;
      rx_full_lvl_next              = rx_full_lvl_reg;
      rx_res_lvl_next               = rx_res_lvl_reg;
      // Mode writes beyond five are ignored so the mode stays legal
      if (wr_hit && (reg_addr == RFC_ADDR_MODE) && (reg_wdata[2:0] <= RFC_MODE_LAST))
         flow_control_mode_number_next = reg_wdata[2:0];
      if (rts_wr)
      begin
         sw_rts_next = reg_wdata[0];
         if (flow_control_mode_number_reg == RFC_MODE_NONE)
            flow_control_mode_number_next = RFC_MODE_MANUAL;
      end
      if (wr_hit && (reg_addr == RFC_ADDR_EXT))
         ext_bits_next = reg_wdata[7:0];
      if (wr_hit && (reg_addr == RFC_ADDR_BAUD))
         baud_div_next = reg_wdata[15:0];
      if (wr_hit && (reg_addr == RFC_ADDR_RXFULL))
         rx_full_lvl_next = reg_wdata[4:0];
      if (wr_hit && (reg_addr == RFC_ADDR_RXRES))
         rx_res_lvl_next = reg_wdata[4:0];

      rx_pop     = reg_rd && (reg_addr == RFC_ADDR_RXDATA);
      rdata_next = '0;
      if (reg_rd)
      begin
         case (reg_addr)
            RFC_ADDR_MODE:    rdata_next[2:0]  = flow_control_mode_number_reg;
            RFC_ADDR_RTS:     rdata_next[0]    = sw_rts_reg;
            RFC_ADDR_EXT:     rdata_next[7:0]  = ext_bits_reg;
            RFC_ADDR_BAUD:    rdata_next[15:0] = baud_div_reg;
            RFC_ADDR_RXFULL:  rdata_next[4:0]  = rx_full_lvl_reg;
            RFC_ADDR_RXRES:   rdata_next[4:0]  = rx_res_lvl_reg;
            RFC_ADDR_TXLEVEL:
            begin
               rdata_next[RFC_TXAW:0]     = txf_level;
               rdata_next[16+RFC_RXAW:16] = rxf_level;
            end
            RFC_ADDR_STATUS:
            begin
               rdata_next[RFC_ST_RTS]             = rts_reg;
               rdata_next[RFC_ST_CTS]             = cts_ok;
               rdata_next[RFC_ST_BUSY]            = (tx_st_reg != RFC_TX_IDLE);
               rdata_next[RFC_ST_TXE]             = txf_empty;
               rdata_next[RFC_ST_TXF]             = txf_full;
               rdata_next[RFC_ST_RXE]             = rxf_empty;
               rdata_next[RFC_ST_MODE+2:RFC_ST_MODE] = flow_control_mode_number_reg;
            end
            default:          rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         flow_control_mode_number_reg <= RFC_MODE_NONE;
         sw_rts_reg                   <= 1'b0;
         ext_bits_reg                 <= RFC_EXT_RST;
         baud_div_reg                 <= RFC_BAUD_RST;
         rx_full_lvl_reg              <= RFC_RXFULL_RST;
         rx_res_lvl_reg               <= RFC_RXRES_RST;
         rdata_reg                    <= '0;
         rd_rx_reg                    <= 1'b0;
      end
      else
      begin
         flow_control_mode_number_reg <= flow_control_mode_number_next;
         sw_rts_reg                   <= sw_rts_next;
         ext_bits_reg                 <= ext_bits_next;
         baud_div_reg                 <= baud_div_next;
         rx_full_lvl_reg              <= rx_full_lvl_next;
         rx_res_lvl_reg               <= rx_res_lvl_next;
         rdata_reg                    <= rdata_next;
         rd_rx_reg                    <= rx_pop;
      end
   end

   // Receive data come from the FIFO's own read register, one cycle after the strobe
   assign reg_rdata = rd_rx_reg ? {{(RFC_DW-8){1'b0}}, rxf_data} : rdata_reg;

   rfc_fifo #(.AW(RFC_TXAW)) u_txf
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .wr_en   (tx_wr),
      .wr_data (reg_wdata[7:0]),
      .rd_en   (tx_pop),
      .rd_data (txf_data),
      .level   (txf_level),
      .empty   (txf_empty),
      .full    (txf_full)
   );

   rfc_fifo #(.AW(RFC_RXAW)) u_rxf
   (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .wr_en   (rx_valid),
      .wr_data (rx_byte),
      .rd_en   (rx_pop),
      .rd_data (rxf_data),
      .level   (rxf_level),
      .empty   (rxf_empty),
      .full    (rxf_full)
   );

   rfc_rx u_rx
   (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .rxd_sync   (rxd_sync_reg),
      .baud_div   (baud_div_reg),
      .byte_valid (rx_valid),
      .byte_data  (rx_byte)
   );

   // Transmitter, CTS gating and RTS selection
   always_comb
   begin
      auto_mode = (flow_control_mode_number_reg == RFC_MODE_ARTS) ||
                  (flow_control_mode_number_reg == RFC_MODE_FULL);
      hold_mode = auto_mode || (flow_control_mode_number_reg == RFC_MODE_NONE);
      case (flow_control_mode_number_reg)
         RFC_MODE_ACTS,
         RFC_MODE_FULL,
         RFC_MODE_DYN: send_ok = cts_ok;
         default:      send_ok = 1'b1;
      endcase
      baud_tick     = (baud_cnt_reg == 16'h0000);
      baud_cnt_next = baud_tick ? baud_div_reg : baud_cnt_reg - 16'h0001;
      tx_st_next    = tx_st_reg;
      bit_cnt_next  = bit_cnt_reg;
      tx_sh_next    = tx_sh_reg;
      ext_cnt_next  = ext_cnt_reg;
      txd_next      = txd_reg;
      tx_pop        = 1'b0;
      auto_rts_next = auto_rts_reg;
      if (tx_wr && hold_mode)
         auto_rts_next = 1'b1;
      case (tx_st_reg)
         RFC_TX_IDLE:
            // CTS is checked only between characters; a frame in flight finishes
            if (!txf_empty && send_ok)
            begin
               tx_pop     = 1'b1;
               tx_st_next = RFC_TX_LOAD;
            end
            else if (txf_empty && !tx_wr && auto_rts_reg && hold_mode)
               auto_rts_next = 1'b0;
         RFC_TX_LOAD:
         begin
            tx_sh_next    = {1'b1, txf_data, 1'b0};
            bit_cnt_next  = RFC_FRAME_BITS;
            baud_cnt_next = 16'h0000;
            tx_st_next    = RFC_TX_SHIFT;
         end
         RFC_TX_SHIFT:
            if (baud_tick)
            begin
               if (bit_cnt_reg == 4'h0)
               begin
                  // Last stop bit is out; extension runs only when no more data waits
                  ext_cnt_next = ext_bits_reg;
                  if (!txf_empty || ext_bits_reg == 8'h00 ||
                      flow_control_mode_number_reg == RFC_MODE_NONE)
                     tx_st_next = RFC_TX_IDLE;
                  else
                     tx_st_next = RFC_TX_EXT;
               end
               else
               begin
                  txd_next     = tx_sh_reg[0];
                  tx_sh_next   = {1'b1, tx_sh_reg[9:1]};
                  bit_cnt_next = bit_cnt_reg - 4'h1;
               end
            end
         RFC_TX_EXT:
            if (!txf_empty)
               tx_st_next = RFC_TX_IDLE;
            else if (baud_tick)
            begin
               ext_cnt_next = ext_cnt_reg - 8'h01;
               if (ext_cnt_reg == 8'h01)
                  tx_st_next = RFC_TX_IDLE;
            end
         default:
            tx_st_next = RFC_TX_IDLE;
      endcase

      // Hysteresis on receive occupancy
      dyn_rts_next = dyn_rts_reg;
      if ({1'b0, rxf_level} >= {1'b0, rx_full_lvl_reg} || rxf_full)
         dyn_rts_next = 1'b0;
      else if ({1'b0, rxf_level} <= {1'b0, rx_res_lvl_reg})
         dyn_rts_next = 1'b1;

      case (flow_control_mode_number_reg)
         RFC_MODE_NONE:   rts_next = auto_rts_reg || (tx_st_reg != RFC_TX_IDLE);
         RFC_MODE_MANUAL,
         RFC_MODE_ACTS:   rts_next = sw_rts_reg;
         RFC_MODE_ARTS,
         RFC_MODE_FULL:   rts_next = sw_rts_reg || auto_rts_reg || (tx_st_reg != RFC_TX_IDLE);
         RFC_MODE_DYN:    rts_next = dyn_rts_reg;
         default:         rts_next = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         tx_st_reg    <= RFC_TX_IDLE;
         baud_cnt_reg <= 16'h0000;
         bit_cnt_reg  <= 4'h0;
         tx_sh_reg    <= 10'h3FF;
         ext_cnt_reg  <= 8'h00;
         auto_rts_reg <= 1'b0;
         dyn_rts_reg  <= 1'b1;
         rts_reg      <= 1'b0;
         txd_reg      <= 1'b1;
      end
      else
      begin
         tx_st_reg    <= tx_st_next;
         baud_cnt_reg <= baud_cnt_next;
         bit_cnt_reg  <= bit_cnt_next;
         tx_sh_reg    <= tx_sh_next;
         ext_cnt_reg  <= ext_cnt_next;
         auto_rts_reg <= auto_rts_next;
         dyn_rts_reg  <= dyn_rts_next;
         rts_reg      <= rts_next;
         txd_reg      <= txd_next;
      end
   end

   // Line levels: RTS and CTS are active low on the pins
   assign rts_n_pin = ~rts_reg;
   assign txd_pin   = txd_reg;

endmodule // rfc_flow_ctl

/* pkg/rfc_pkg.sv */
// Package with register map, mode codes and timing constants for the flow control block
package rfc_pkg;

   // Register indices on the plain register port
   localparam logic [3:0] RFC_ADDR_TXDATA  = 4'h0;
   localparam logic [3:0] RFC_ADDR_MODE    = 4'h1;
   localparam logic [3:0] RFC_ADDR_RTS     = 4'h2;
   localparam logic [3:0] RFC_ADDR_EXT     = 4'h3;
   localparam logic [3:0] RFC_ADDR_BAUD    = 4'h4;
   localparam logic [3:0] RFC_ADDR_RXFULL  = 4'h5;
   localparam logic [3:0] RFC_ADDR_RXRES   = 4'h6;
   localparam logic [3:0] RFC_ADDR_STATUS  = 4'h7;
   localparam logic [3:0] RFC_ADDR_RXDATA  = 4'h8;
   localparam logic [3:0] RFC_ADDR_TXLEVEL = 4'h9;

   localparam int RFC_DW = 32;

   // Mode numbers
   localparam logic [2:0] RFC_MODE_NONE   = 3'h0;
   localparam logic [2:0] RFC_MODE_MANUAL = 3'h1;
   localparam logic [2:0] RFC_MODE_ACTS   = 3'h2;
   localparam logic [2:0] RFC_MODE_ARTS   = 3'h3;
   localparam logic [2:0] RFC_MODE_FULL   = 3'h4;
   localparam logic [2:0] RFC_MODE_DYN    = 3'h5;
   localparam logic [2:0] RFC_MODE_LAST   = 3'h5;

   // Buffer sizes (entries, log2)
   localparam int RFC_TXAW = 3;
   localparam int RFC_RXAW = 4;

   // Reset values
   localparam logic [15:0] RFC_BAUD_RST   = 16'h01B2;
   localparam logic [7:0]  RFC_EXT_RST    = 8'h00;
   localparam logic [4:0]  RFC_RXFULL_RST = 5'h0C;
   localparam logic [4:0]  RFC_RXRES_RST  = 5'h04;

   // Frame: start + 8 data + stop
   localparam logic [3:0] RFC_FRAME_BITS = 4'hA;

   // System clock frequency in Hz
   localparam int RFC_CLK_HZ = 50000000;

   // Status bit positions
   localparam int RFC_ST_RTS   = 0;
   localparam int RFC_ST_CTS   = 1;
   localparam int RFC_ST_BUSY  = 2;
   localparam int RFC_ST_TXE   = 3;
   localparam int RFC_ST_TXF   = 4;
   localparam int RFC_ST_RXE   = 5;
   localparam int RFC_ST_MODE  = 8;

endpackage

/* rtl/rfc_fifo.sv */
// Small synchronous FIFO with registered read data
`timescale 1ns/100ps
module rfc_fifo
   import rfc_pkg::*;
#(
   parameter int AW = 3
)
(
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   input  wire logic          wr_en,
   input  wire logic [7:0]    wr_data,
   input  wire logic          rd_en,
   output logic      [7:0]    rd_data,
   output logic      [AW:0]   level,
   output logic               empty,
   output logic               full
);

   logic [7:0]  mem_reg [0:(1<<AW)-1];
   logic [AW:0] wp_reg;
   logic [AW:0] wp_next;
   logic [AW:0] rp_reg;
   logic [AW:0] rp_next;
   logic [7:0]  rd_data_reg;
   logic [7:0]  rd_data_next;
   logic        do_wr;
   logic        do_rd;

   always_comb
   begin
      do_wr        = wr_en && !full;
      do_rd        = rd_en && !empty;
      wp_next      = wp_reg + (AW+1)'(do_wr);
      rp_next      = rp_reg + (AW+1)'(do_rd);
      rd_data_next = do_rd ? mem_reg[rp_reg[AW-1:0]] : rd_data_reg;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         wp_reg      <= '0;
         rp_reg      <= '0;
         rd_data_reg <= 8'h00;
      end
      else
      begin
         wp_reg      <= wp_next;
         rp_reg      <= rp_next;
         rd_data_reg <= rd_data_next;
      end
   end

   // Storage needs no reset; it is gated by the pointers
   always_ff @(posedge sys_clk)
   begin
      if (do_wr)
         mem_reg[wp_reg[AW-1:0]] <= wr_data;
   end

   assign level   = wp_reg - rp_reg;
   assign empty   = (wp_reg == rp_reg);
   assign full    = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
   assign rd_data = rd_data_reg;

endmodule // rfc_fifo

/* rtl/rfc_rx.sv */
// Serial receiver: 8N1 frames into a byte strobe
`timescale 1ns/100ps
module rfc_rx
   import rfc_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   input  wire logic          rxd_sync,
   input  wire logic [15:0]   baud_div,
   output logic               byte_valid,
   output logic      [7:0]    byte_data
);

   typedef enum logic [1:0] {RFC_RX_IDLE, RFC_RX_BITS, RFC_RX_STOP} rfc_rx_e;

   rfc_rx_e     st_reg;
   rfc_rx_e     st_next;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [2:0]  bit_reg;
   logic [2:0]  bit_next;
   logic [7:0]  sh_reg;
   logic [7:0]  sh_next;
   logic        vld_reg;
   logic        vld_next;

   always_comb
   begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      sh_next  = sh_reg;
      vld_next = 1'b0;
      case (st_reg)
         RFC_RX_IDLE:
            if (!rxd_sync)
            begin
               // Wait one and a half bits to land mid bit 0
               cnt_next = baud_div + {1'b0, baud_div[15:1]};
               bit_next = 3'h0;
               st_next  = RFC_RX_BITS;
            end
         RFC_RX_BITS:
            if (cnt_reg != 16'h0000)
               cnt_next = cnt_reg - 16'h0001;
            else
            begin
               sh_next  = {rxd_sync, sh_reg[7:1]};
               cnt_next = baud_div;
               bit_next = bit_reg + 3'h1;
               if (bit_reg == 3'h7)
                  st_next = RFC_RX_STOP;
            end
         RFC_RX_STOP:
            if (cnt_reg != 16'h0000)
               cnt_next = cnt_reg - 16'h0001;
            else
            begin
               vld_next = rxd_sync;
               st_next  = RFC_RX_IDLE;
            end
         default:
            st_next = RFC_RX_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_reg  <= RFC_RX_IDLE;
         cnt_reg <= 16'h0000;
         bit_reg <= 3'h0;
         sh_reg  <= 8'h00;
         vld_reg <= 1'b0;
      end
      else
      begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         sh_reg  <= sh_next;
         vld_reg <= vld_next;
      end
   end

   assign byte_valid = vld_reg;
   assign byte_data  = sh_reg;

endmodule // rfc_rx

/* sim/rfc_flow_ctl_properties.sv */
// Port checker for the flow control block, bound to the top module
`timescale 1ns/100ps
module rfc_flow_ctl_properties
   import rfc_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              sys_rst,
   input wire logic [3:0]        reg_addr,
   input wire logic [RFC_DW-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [RFC_DW-1:0] reg_rdata,
   input wire logic              cts_n_pin,
   input wire logic              txd_pin,
   input wire logic              rts_n_pin
);
   logic [2:0]  mode_reg, mode_next;
   logic        sw_reg, sw_next;
   logic [15:0] baud_reg, baud_next;
   logic [3:0]  quiet_reg, quiet_next;
   logic [20:0] off_reg, off_next;
   logic        man, aut, gat;
   assign man = (mode_reg == RFC_MODE_MANUAL) || (mode_reg == RFC_MODE_ACTS);
   assign aut = (mode_reg == RFC_MODE_ARTS) || (mode_reg == RFC_MODE_FULL);
   assign gat = (mode_reg == RFC_MODE_ACTS) || (mode_reg == RFC_MODE_FULL) || (mode_reg == RFC_MODE_DYN);
   always_comb
   begin
      mode_next  = mode_reg;
      sw_next    = sw_reg;
      baud_next  = baud_reg;
      quiet_next = (&quiet_reg) ? quiet_reg : quiet_reg + 4'h1;
      off_next   = !(cts_n_pin && txd_pin) ? 21'h0 : off_reg + {20'h0, !(&off_reg)};
      if (reg_wr)
      begin
         quiet_next = 4'h0;
         if (reg_addr == RFC_ADDR_MODE && reg_wdata[2:0] <= RFC_MODE_LAST)
            mode_next = reg_wdata[2:0];
         if (reg_addr == RFC_ADDR_RTS)
         begin
            sw_next = reg_wdata[0];
            if (mode_reg == RFC_MODE_NONE)
               mode_next = RFC_MODE_MANUAL;
         end
         if (reg_addr == RFC_ADDR_BAUD)
            baud_next = reg_wdata[15:0];
      end
   end
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         mode_reg  <= RFC_MODE_NONE;
         sw_reg    <= 1'b0;
         baud_reg  <= RFC_BAUD_RST;
         quiet_reg <= 4'h0;
         off_reg   <= 21'h0;
      end
      else
      begin
         mode_reg  <= mode_next;
         sw_reg    <= sw_next;
         baud_reg  <= baud_next;
         quiet_reg <= quiet_next;
         off_reg   <= off_next;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_rts_wr0;
      reg_wr && reg_addr == RFC_ADDR_RTS && mode_reg == RFC_MODE_NONE;
   endsequence
   sequence s_stat_rd;
      reg_rd && reg_addr == RFC_ADDR_STATUS;
   endsequence
   property p_reset;
      $fell(sys_rst) |-> txd_pin && rts_n_pin && reg_rdata == '0;
   endproperty
   property p_switch;
      s_rts_wr0 ##1 !reg_wr ##1 s_stat_rd |=> reg_rdata[10:8] == RFC_MODE_MANUAL;
   endproperty
   property p_mode_rd;
      reg_rd && reg_addr == RFC_ADDR_STATUS && quiet_reg > 4'h1 |=> reg_rdata[10:8] == mode_reg;
   endproperty
   property p_man_chg;
      man && $changed(rts_n_pin) |-> quiet_reg < 4'h4;
   endproperty
   property p_man_val;
      man && quiet_reg > 4'h3 |-> rts_n_pin == !sw_reg;
   endproperty
   property p_auto_sw;
      aut && sw_reg && quiet_reg > 4'h3 |-> !rts_n_pin;
   endproperty
   property p_tx_rts;
      (aut || mode_reg == RFC_MODE_NONE) && quiet_reg > 4'h3 && !txd_pin |-> !rts_n_pin;
   endproperty
   property p_unmapped;
      reg_rd && reg_addr > RFC_ADDR_TXLEVEL |=> reg_rdata == '0;
   endproperty
   property p_gate;
      gat && off_reg > {baud_reg, 4'h0} |-> txd_pin;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not idle after reset");
   a_switch: assert property (p_switch) else $error("no manual mode after RTS write");
   a_mode_rd: assert property (p_mode_rd) else $error("status mode wrong");
   a_man_chg: assert property (p_man_chg) else $error("RTS moved on its own");
   a_man_val: assert property (p_man_val) else $error("RTS differs from software");
   a_auto_sw: assert property (p_auto_sw) else $error("software RTS lost");
   a_tx_rts: assert property (p_tx_rts) else $error("RTS off while sending");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_gate: assert property (p_gate) else $error("frame started without CTS");
endmodule // rfc_flow_ctl_properties

bind rfc_flow_ctl rfc_flow_ctl_properties u_props (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .cts_n_pin, .txd_pin, .rts_n_pin);

/* sim/rfc_dce_model.sv */
// Modem-side partner: CTS source, serial sender and receiver
`timescale 1ns/100ps
module rfc_dce_model
#(
   parameter int BIT = 4
)
(
   input  wire logic sys_clk,
   input  wire logic cts_ok,
   input  wire logic txd_pin,
   output logic      cts_n_pin,
   output logic      rxd_pin
);
   int         got = 0;
   logic [7:0] last;
   assign cts_n_pin = !cts_ok;
   initial rxd_pin = 1'b1;
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rxd_pin <= f[i];
         repeat (BIT) @(posedge sys_clk);
      end
   endtask
   always
   begin
      @(negedge txd_pin);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT) @(posedge sys_clk);
         last[i] = txd_pin;
      end
      repeat (BIT) @(posedge sys_clk);
      got++;
   end
endmodule // rfc_dce_model

/* sim/tb.sv */
// Self-checking bench for the flow control block
`timescale 1ns/100ps
module tb
   import rfc_pkg::*;
;
   logic              sys_clk   = 1'b0;
   logic              sys_rst   = 1'b1;
   logic [3:0]        reg_addr  = 4'h0;
   logic [RFC_DW-1:0] reg_wdata = '0;
   logic              reg_wr    = 1'b0;
   logic              reg_rd    = 1'b0;
   logic              cts_ok    = 1'b0;
   logic [RFC_DW-1:0] reg_rdata, d;
   logic              cts_n_pin, rxd_pin, txd_pin, rts_n_pin;
   int                fails     = 0;
   int                tests_run = 0;
   int                cyc       = 0;
   always #10 sys_clk = ~sys_clk;
   rfc_flow_ctl uut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cts_n_pin, .rxd_pin,
      .txd_pin, .rts_n_pin);
   rfc_dce_model dce (.sys_clk, .cts_ok, .txd_pin, .cts_n_pin, .rxd_pin);
   task automatic finish_test();
      if (fails == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         finish_test();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] exp);
      rd(a);
      chk(d, exp);
   endtask
   task automatic wait_rx(input int n);
      for (int i = 0; i < 3000 && dce.got < n; i++)
         @(posedge sys_clk);
      chk(dce.got, n);
   endtask
   task automatic tail(input int n);
      wait_rx(n);
      step(4);
      chk(rts_n_pin, 1'b0);
      step(12);
      chk(rts_n_pin, 1'b1);
   endtask
   task automatic t_reset();
      chk({txd_pin, rts_n_pin}, 2'h3);
      rc(RFC_ADDR_MODE, RFC_MODE_NONE);
      rc(RFC_ADDR_BAUD, RFC_BAUD_RST);
      rc(RFC_ADDR_EXT, RFC_EXT_RST);
      rc(RFC_ADDR_RXFULL, RFC_RXFULL_RST);
      rc(RFC_ADDR_RXRES, RFC_RXRES_RST);
      rc(4'hC, 32'h0);
      wr(RFC_ADDR_BAUD, 32'h3);
      wr(RFC_ADDR_EXT, 32'h2);
      rc(RFC_ADDR_EXT, 32'h2);
   endtask
   task automatic t_mode0();
      wr(RFC_ADDR_TXDATA, 32'hA5);
      step(3);
      chk(rts_n_pin, 1'b0);
      wait_rx(1);
      chk(dce.last, 8'hA5);
      step(6);
      chk(rts_n_pin, 1'b1);
   endtask
   task automatic t_manual();
      wr(RFC_ADDR_RTS, 32'h1);
      rd(RFC_ADDR_STATUS);
      chk(d[10:8], RFC_MODE_MANUAL);
      chk(rts_n_pin, 1'b0);
      wr(RFC_ADDR_RTS, 32'h0);
      wr(RFC_ADDR_TXDATA, 32'h3C);
      wait_rx(2);
      chk({rts_n_pin, dce.last}, 9'h13C);
      step(4);
   endtask
   task automatic t_modes();
      for (int m = 0; m < 8; m++)
      begin
         wr(RFC_ADDR_MODE, m);
         rc(RFC_ADDR_MODE, (m < 6) ? m : 5);
         rd(RFC_ADDR_STATUS);
         chk(d[10:8], (m < 6) ? m : 5);
      end
   endtask
   task automatic t_mode2();
      wr(RFC_ADDR_MODE, 32'h2);
      wr(RFC_ADDR_TXDATA, 32'h5A);
      step(100);
      chk({rts_n_pin, dce.got[3:0]}, 5'h12);
      rc(RFC_ADDR_STATUS, 32'h220);
      cts_ok <= 1'b1;
      wait_rx(3);
      chk(dce.last, 8'h5A);
      step(4);
   endtask
   task automatic t_mode3();
      cts_ok <= 1'b0;
      wr(RFC_ADDR_MODE, 32'h3);
      wr(RFC_ADDR_TXDATA, 32'h11);
      step(3);
      chk(rts_n_pin, 1'b0);
      tail(4);
      wr(RFC_ADDR_RTS, 32'h1);
      wr(RFC_ADDR_TXDATA, 32'h22);
      wr(RFC_ADDR_TXDATA, 32'h33);
      wr(RFC_ADDR_RTS, 32'h0);
      tail(6);
      wr(RFC_ADDR_RTS, 32'h1);
      step(60);
      chk(rts_n_pin, 1'b0);
      wr(RFC_ADDR_RTS, 32'h0);
      step(4);
      chk(rts_n_pin, 1'b1);
   endtask
   task automatic t_mode4();
      wr(RFC_ADDR_MODE, 32'h4);
      wr(RFC_ADDR_TXDATA, 32'h44);
      step(3);
      chk(rts_n_pin, 1'b0);
      step(100);
      chk(dce.got, 6);
      cts_ok <= 1'b1;
      tail(7);
      chk(dce.last, 8'h44);
   endtask
   task automatic t_mode5();
      wr(RFC_ADDR_RXFULL, 32'h6);
      wr(RFC_ADDR_RXRES, 32'h2);
      wr(RFC_ADDR_MODE, 32'h5);
      step(4);
      chk(rts_n_pin, 1'b0);
      cts_ok <= 1'b0;
      wr(RFC_ADDR_TXDATA, 32'h55);
      for (int i = 0; i < 6; i++)
         dce.send(8'h60 + i);
      step(8);
      chk({rts_n_pin, dce.got[3:0]}, 5'h17);
      for (int i = 0; i < 3; i++)
         rc(RFC_ADDR_RXDATA, 8'h60 + i);
      step(4);
      chk(rts_n_pin, 1'b1);
      rc(RFC_ADDR_RXDATA, 32'h63);
      step(4);
      chk(rts_n_pin, 1'b0);
      cts_ok <= 1'b1;
      wait_rx(8);
      chk(dce.last, 8'h55);
   endtask
   initial
   begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_mode0();
      t_manual();
      t_modes();
      t_mode2();
      t_mode3();
      t_mode4();
      t_mode5();
      finish_test();
   end
endmodule // tb
